// [shared/fdma_map.svh]
`ifndef FDMA_MAP_SVH
`define FDMA_MAP_SVH
// Channel count and data path
`define FDMA_NCH 4
`define FDMA_FIFO_W 32
`define FDMA_FIFO_D 16
// Width codes
`define FDMA_W_LONG 2'h0
`define FDMA_W_BYTE 2'h1
`define FDMA_W_WORD 2'h2
`define FDMA_W_LINE 2'h3
// Bytes per width
`define FDMA_B_BYTE 5'h01
`define FDMA_B_WORD 5'h02
`define FDMA_B_LONG 5'h04
`define FDMA_B_LINE 5'h10
// Widest single bus beat in bytes
`define FDMA_B_BEAT 5'h04
// Chunk bytes = 1 << (chunk code + shift)
`define FDMA_BW_NONE 3'h0
`define FDMA_BW_SHIFT 5'h08
// Reset values
`define FDMA_PTR_RST 32'h0000_0000
`define FDMA_CNT_RST 24'h00_0000
`endif

// [shared/fdma_pkg.sv]
package fdma_pkg;
  typedef enum logic [2:0] {
    ST_IDLE, ST_LOAD, ST_READ, ST_WRITE, ST_SINGLE, ST_GAP
  } fdma_state_e;
  typedef logic [1:0] fdma_width_t;
  typedef logic [2:0] fdma_bw_t;
  typedef logic [23:0] fdma_cnt_t;
endpackage : fdma_pkg

// [rtl/fdma_sequencer.sv]
`timescale 1ns/1ns
`default_nettype none
`include "fdma_map.svh"

// ---------------------------------------------
// Data FIFO between read and write phases
// ---------------------------------------------
module fdma_fifo #(
  parameter int W = `FDMA_FIFO_W,
  parameter int D = `FDMA_FIFO_D
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic flush,
  input wire logic inValid,
  output logic inReady,
  input wire logic [W-1:0] inData,
  output logic outValid,
  input wire logic outReady,
  output logic [W-1:0] outData
);
  localparam int AW = $clog2(D);
  logic [W-1:0] mem [D];
  logic [AW-1:0] wr_q;
  logic [AW-1:0] rd_q;
  logic [AW:0] num_q;
  wire push = inValid & inReady;
  wire pop = outValid & outReady;
  // Full and empty straight from the fill count
  assign inReady = num_q != (AW+1)'(D);
  assign outValid = num_q != '0;
  assign outData = mem[rd_q];
  // Storage, no reset needed
  always_ff @(posedge clk) begin
    if (push) mem[wr_q] <= inData;
  end
  // Pointers; flush drops leftovers of an aborted transfer
  always_ff @(posedge clk) begin
    if (!rst_n || flush) begin
      wr_q <= '0;
      rd_q <= '0;
      num_q <= '0;
    end else begin
      if (push) wr_q <= wr_q + 1'b1;
      if (pop) rd_q <= rd_q + 1'b1;
      num_q <= num_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule : fdma_fifo

// ---------------------------------------------
// Four channel transfer sequencer
// ---------------------------------------------
module fdma_sequencer (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [3:0] chStart,
  output logic [3:0] startBit_q,
  input wire logic [3:0] extReqEnable,
  input wire logic [3:0] extAskN,
  input wire logic [3:0] cycleSteal,
  input wire logic [3:0] singleAddr,
  input wire logic [3:0] singleDirWrite,
  input wire logic [3:0] srcStep,
  input wire logic [3:0] dstStep,
  input wire logic [3:0] autoAlign,
  input wire logic [3:0] irqOnFinish,
  input wire fdma_pkg::fdma_width_t [3:0] srcWidth,
  input wire fdma_pkg::fdma_width_t [3:0] dstWidth,
  input wire fdma_pkg::fdma_bw_t [3:0] bwChunk,
  input wire logic [3:0] cfgLoad,
  input wire logic [31:0] cfgSrc,
  input wire logic [31:0] cfgDst,
  input wire fdma_pkg::fdma_cnt_t cfgCount,
  input wire logic [3:0] doneWrite,
  output logic [3:0] done_q,
  output logic [3:0] busy_q,
  output logic [3:0] pend_q,
  output logic [3:0] srcFault_q,
  output logic [3:0] dstFault_q,
  output logic [3:0] cfgFault_q,
  output logic [3:0] irqLine_q,
  input wire logic [3:0][7:0] irqVector,
  input wire logic irqAck,
  input wire logic [1:0] irqAckChan,
  output logic [7:0] vecData_q,
  output logic vecValid_q,
  output logic busReq_q,
  input wire logic busGrant,
  output logic busValid_q,
  output logic [31:0] busAddr_q,
  output logic busWrite_q,
  output fdma_pkg::fdma_width_t busSize_q,
  output logic [31:0] busWdata_q,
  input wire logic [31:0] busRdata,
  input wire logic busAck,
  input wire logic busErr
);
  import fdma_pkg::*;

  function automatic logic [4:0] wb(input fdma_width_t w);
    logic [4:0] b;
    b = `FDMA_B_LONG;
    unique case (w)
      `FDMA_W_BYTE: b = `FDMA_B_BYTE;
      `FDMA_W_WORD: b = `FDMA_B_WORD;
      `FDMA_W_LINE: b = `FDMA_B_LINE;
      `FDMA_W_LONG: b = `FDMA_B_LONG;
    endcase
    return b;
  endfunction : wb

  function automatic logic [4:0] beat(input logic [4:0] b);
    return (b > `FDMA_B_BEAT) ? `FDMA_B_BEAT : b;
  endfunction : beat

  fdma_state_e st_q;
  logic [1:0] act_q;
  logic [31:0] sPtr_q [4];
  logic [31:0] dPtr_q [4];
  fdma_cnt_t cnt_q [4];
  logic [4:0] rdLeft_q;
  logic [4:0] wrLeft_q;
  logic [31:0] asm_q;
  logic [2:0] asmCnt_q;
  logic [31:0] hold_q;
  logic [2:0] hCnt_q;
  logic [1:0] hOff_q;
  logic [3:0] ask1_q;
  logic [3:0] ask2_q;
  logic [3:0] cfgBad;
  logic [3:0] elig;
  logic [3:0][3:0] key;
  logic [3:0] swap;
  logic [1:0] win;
  logic anyPend;
  logic [3:0] best;

  // ---------------------------------------------
  // Active channel decode
  // ---------------------------------------------
  wire [4:0] sB = wb(srcWidth[act_q]);
  wire [4:0] dB = wb(dstWidth[act_q]);
  wire [4:0] sBeat = beat(sB);
  wire [4:0] dBeat = beat(dB);
  wire single = singleAddr[act_q];
  wire [4:0] xfer = (sB > dB) ? sB : dB;
  wire [4:0] decAmt = single ? sBeat : xfer;
  wire fdma_cnt_t cntAfter = cnt_q[act_q] - 24'(decAmt);
  wire zeroNext = cntAfter == '0;
  wire fdma_bw_t bw = bwChunk[act_q];
  wire [4:0] bwSh = 5'(bw) + `FDMA_BW_SHIFT;
  wire fdma_cnt_t chunkMask = (24'h00_0001 << bwSh) - 24'h00_0001;
  wire bwOn = bw != `FDMA_BW_NONE;
  wire bndNext = bwOn & ~cycleSteal[act_q] & ((cntAfter & chunkMask) == '0);
  wire issueOk = busGrant & ~busValid_q;
  wire okNow = busValid_q & busAck & ~busErr;
  wire errNow = busValid_q & busErr;
  wire rdAck = okNow & (st_q == ST_READ);
  wire wrAck = okNow & (st_q == ST_WRITE);
  wire sgAck = okNow & (st_q == ST_SINGLE);
  wire lastWr = wrAck & (wrLeft_q == dBeat);
  wire decNow = lastWr | sgAck;
  wire finishNow = decNow & zeroNext;
  wire rependNow = decNow & ~zeroNext & bndNext;
  wire abortNow = doneWrite[act_q] & (st_q != ST_IDLE);
  wire selNow = (st_q == ST_IDLE) & anyPend;
  wire fInReady;
  wire fOutValid;
  wire [31:0] fOutData;
  wire rdIssue = (st_q == ST_READ) & issueOk & fInReady & (rdLeft_q != '0);
  wire wrIssue = (st_q == ST_WRITE) & issueOk & (hCnt_q != '0);
  wire sgIssue = (st_q == ST_SINGLE) & issueOk;
  wire lastBeat = (st_q == ST_WRITE) ? (wrLeft_q == dBeat) : 1'b1;
  wire dropReq = (wrIssue | sgIssue) & lastBeat & bndNext & ~zeroNext;
  wire [31:0] rdLane = busRdata & ~(32'hFFFF_FFFF << {sBeat[2:0], 3'h0});
  wire [31:0] asmNext = asm_q | (rdLane << {asmCnt_q[1:0], 3'h0});
  wire [2:0] asmCntNext = asmCnt_q + sBeat[2:0];
  wire fPush = rdAck & (asmCntNext[2] | (rdLeft_q == sBeat));
  wire fPop = (st_q == ST_WRITE) & (hCnt_q == '0) & (wrLeft_q != '0);
  wire [4:0] popBytes = (wrLeft_q > `FDMA_B_BEAT) ? `FDMA_B_BEAT : wrLeft_q;

  // ---------------------------------------------
  // Request pins and arbitration
  // ---------------------------------------------
  // Pins come from outside; two stages before use
  always_ff @(posedge clk) begin
    ask1_q <= rst_n ? extAskN : 4'hF;
    ask2_q <= rst_n ? ask1_q : 4'hF;
  end

  // Chunk code zero pulls a channel just ahead of its lower neighbour
  assign swap[0] = 1'b0;
  for (genvar n = 1; n < `FDMA_NCH; n++) begin : g_swap
    assign swap[n] = (bwChunk[n] == `FDMA_BW_NONE) &
      (bwChunk[n-1] != `FDMA_BW_NONE) & ~swap[n-1];
  end
  for (genvar n = 0; n < `FDMA_NCH; n++) begin : g_key
    assign key[n] = swap[n] ? 4'(2*n - 1) : 4'(2*n + 2);
  end

  // Lowest key among pending channels wins
  always_comb begin
    win = 2'h0;
    anyPend = 1'b0;
    best = 4'hF;
    for (int i = 0; i < `FDMA_NCH; i++) begin
      if (pend_q[i] && key[i] < best) begin
        best = key[i];
        win = 2'(i);
        anyPend = 1'b1;
      end
    end
  end

  // ---------------------------------------------
  // Per channel state
  // ---------------------------------------------
  for (genvar n = 0; n < `FDMA_NCH; n++) begin : g_ch
    wire mine = act_q == 2'(n);
    wire running = mine & (st_q != ST_IDLE);
    wire reqRaw = startBit_q[n] | (extReqEnable[n] & ~ask2_q[n]);
    wire [4:0] cs = wb(srcWidth[n]);
    wire [4:0] cd = wb(dstWidth[n]);
    wire [4:0] cx = singleAddr[n] ? cs : ((cs > cd) ? cs : cd);
    wire sAl = (sPtr_q[n][4:0] & (cs - 5'h01)) == '0;
    wire dAl = (dPtr_q[n][4:0] & (cd - 5'h01)) == '0;
    wire cAl = (cnt_q[n][4:0] & (cx - 5'h01)) == '0;
    wire cAlS = (cnt_q[n][4:0] & (cs - 5'h01)) == '0;
    wire cAlD = (cnt_q[n][4:0] & (cd - 5'h01)) == '0;
    wire aaBad = (cs >= cd) ? ~(dAl & cAlD) : ~(sAl & cAlS);
    wire plainBad = singleAddr[n] ? ~(sAl & cAl) : ~(sAl & dAl & cAl);
    assign cfgBad[n] = (cnt_q[n] == '0) |
      ((autoAlign[n] & ~singleAddr[n]) ? aaBad : plainBad);
    assign elig[n] = reqRaw & ~pend_q[n] & ~done_q[n] & ~cfgFault_q[n] & ~running;

    // Status flags; clear first so a same-cycle set wins
    always_ff @(posedge clk) begin
      if (!rst_n) begin
        startBit_q[n] <= 1'b0;
        {done_q[n], busy_q[n], pend_q[n]} <= 3'h0;
        {srcFault_q[n], dstFault_q[n], cfgFault_q[n]} <= 3'h0;
      end else begin
        if (chStart[n]) startBit_q[n] <= 1'b1;
        else if ((selNow && win == 2'(n)) || elig[n]) startBit_q[n] <= 1'b0;
        if (doneWrite[n]) begin
          {done_q[n], busy_q[n], pend_q[n]} <= 3'h0;
          {srcFault_q[n], dstFault_q[n], cfgFault_q[n]} <= 3'h0;
        end
        if (elig[n] && cfgBad[n]) cfgFault_q[n] <= 1'b1;
        if (elig[n] && !cfgBad[n]) pend_q[n] <= 1'b1;
        if (selNow && win == 2'(n)) begin
          pend_q[n] <= 1'b0;
          busy_q[n] <= 1'b1;
        end
        if (mine && rependNow) pend_q[n] <= 1'b1;
        if (mine && (finishNow || errNow)) begin
          done_q[n] <= 1'b1;
          busy_q[n] <= 1'b0;
        end
        if (mine && errNow) begin
          srcFault_q[n] <= 1'b1;
          if (st_q == ST_WRITE) dstFault_q[n] <= 1'b1;
        end
      end
    end

    // Interrupt line follows done or fault
    always_ff @(posedge clk) begin
      if (!rst_n) irqLine_q[n] <= 1'b0;
      else irqLine_q[n] <= irqOnFinish[n] & (done_q[n] | cfgFault_q[n]);
    end

    // Pointers and count; software load overrides stepping
    always_ff @(posedge clk) begin
      if (!rst_n) begin
        sPtr_q[n] <= `FDMA_PTR_RST;
        dPtr_q[n] <= `FDMA_PTR_RST;
        cnt_q[n] <= `FDMA_CNT_RST;
      end else if (cfgLoad[n]) begin
        sPtr_q[n] <= cfgSrc;
        dPtr_q[n] <= cfgDst;
        cnt_q[n] <= cfgCount;
      end else if (mine) begin
        if ((rdAck || sgAck) && srcStep[n]) sPtr_q[n] <= sPtr_q[n] + 32'(sBeat);
        if (wrAck && dstStep[n] && !single) dPtr_q[n] <= dPtr_q[n] + 32'(dBeat);
        if (decNow) cnt_q[n] <= cntAfter;
      end
    end
  end

  // ---------------------------------------------
  // Data buffer
  // ---------------------------------------------
  fdma_fifo #(.W(`FDMA_FIFO_W), .D(`FDMA_FIFO_D)) u_fifo (
    .clk(clk),
    .rst_n(rst_n),
    .flush(abortNow | errNow),
    .inValid(fPush),
    .inReady(fInReady),
    .inData(asmNext),
    .outValid(fOutValid),
    .outReady(fPop),
    .outData(fOutData)
  );

  // ---------------------------------------------
  // Sequencer
  // ---------------------------------------------
  // Main state and per-transfer byte counters
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st_q <= ST_IDLE;
      act_q <= 2'h0;
      rdLeft_q <= '0;
      wrLeft_q <= '0;
    end else if (errNow || abortNow) begin
      st_q <= ST_IDLE;
    end else begin
      unique case (st_q)
        ST_IDLE: if (selNow) begin
          act_q <= win;
          st_q <= ST_LOAD;
        end
        ST_LOAD: begin
          rdLeft_q <= xfer;
          wrLeft_q <= xfer;
          st_q <= single ? ST_SINGLE : ST_READ;
        end
        ST_READ: if (rdAck) begin
          rdLeft_q <= rdLeft_q - sBeat;
          if (rdLeft_q == sBeat) st_q <= ST_WRITE;
        end
        ST_WRITE: if (wrAck) begin
          wrLeft_q <= wrLeft_q - dBeat;
          if (lastWr) begin
            if (zeroNext || cycleSteal[act_q]) st_q <= ST_IDLE;
            else if (bndNext) st_q <= ST_GAP;
            else st_q <= ST_LOAD;
          end
        end
        ST_SINGLE: if (sgAck) begin
          if (zeroNext || cycleSteal[act_q]) st_q <= ST_IDLE;
          else if (bndNext) st_q <= ST_GAP;
        end
        ST_GAP: st_q <= ST_IDLE;
      endcase
    end
  end

  // Read packing and write unpacking around the FIFO
  always_ff @(posedge clk) begin
    if (!rst_n || st_q == ST_LOAD) begin
      asm_q <= '0;
      asmCnt_q <= '0;
      hCnt_q <= '0;
      hOff_q <= '0;
      hold_q <= '0;
    end else begin
      if (rdAck) asm_q <= fPush ? '0 : asmNext;
      if (rdAck) asmCnt_q <= fPush ? 3'h0 : asmCntNext;
      if (fPop && fOutValid) begin
        hold_q <= fOutData;
        hCnt_q <= popBytes[2:0];
        hOff_q <= 2'h0;
      end else if (wrAck) begin
        hCnt_q <= hCnt_q - dBeat[2:0];
        hOff_q <= hOff_q + dBeat[1:0];
      end
    end
  end

  // Bus request: up on selection, down before a boundary or when idle
  always_ff @(posedge clk) begin
    if (!rst_n) busReq_q <= 1'b0;
    else if (selNow) busReq_q <= 1'b1;
    else if (dropReq || st_q == ST_IDLE || st_q == ST_GAP) busReq_q <= 1'b0;
    else if (errNow || abortNow) busReq_q <= 1'b0;
  end

  // Bus cycle launch; fields hold until ack, error or abort
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      busValid_q <= 1'b0;
      busAddr_q <= `FDMA_PTR_RST;
      busWrite_q <= 1'b0;
      busSize_q <= `FDMA_W_LONG;
      busWdata_q <= '0;
    end else if (busValid_q) begin
      if (busAck || busErr || abortNow) busValid_q <= 1'b0;
    end else if (rdIssue || sgIssue) begin
      busValid_q <= 1'b1;
      busAddr_q <= sPtr_q[act_q];
      busWrite_q <= sgIssue & singleDirWrite[act_q];
      busSize_q <= srcWidth[act_q];
    end else if (wrIssue) begin
      busValid_q <= 1'b1;
      busAddr_q <= dPtr_q[act_q];
      busWrite_q <= 1'b1;
      busSize_q <= dstWidth[act_q];
      busWdata_q <= hold_q >> {hOff_q, 3'h0};
    end
  end

  // Vector supply on interrupt acknowledge
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      vecValid_q <= 1'b0;
      vecData_q <= '0;
    end else begin
      vecValid_q <= irqAck;
      if (irqAck) vecData_q <= irqVector[irqAckChan];
    end
  end

  // ---------------------------------------------
  // Checks
  // ---------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence s_lastWrite;
    lastWr && !zeroNext && bndNext;
  endsequence
  sequence s_yield;
    !busReq_q ##1 (st_q == ST_IDLE);
  endsequence

  vector_supply_a: assert property (irqAck |=> vecValid_q &&
    vecData_q == $past(irqVector[irqAckChan])) else $error("vector not supplied");
  start_clear_a: assert property (selNow && !chStart[win] |=>
    !startBit_q[$past(win)]) else $error("start bit not cleared");
  cfg_fault_a: assert property (elig[3] && cfgBad[3] && !doneWrite[3] |=>
    cfgFault_q[3] && !pend_q[3] && !busy_q[3]) else $error("bad config ran");
  count_step_a: assert property (lastWr && !cfgLoad[act_q] |=>
    cnt_q[$past(act_q)] == $past(cntAfter)) else $error("count step wrong");
  steal_one_a: assert property (lastWr && cycleSteal[act_q] |=>
    st_q == ST_IDLE) else $error("cycle steal kept going");
  chunk_yield_a: assert property (s_lastWrite |=> s_yield)
    else $error("no bus yield at chunk");
  error_halt_a: assert property (errNow |=> done_q[$past(act_q)] &&
    srcFault_q[$past(act_q)] && st_q == ST_IDLE && !busValid_q) else $error("error not halted");
  single_addr_a: assert property ($rose(busValid_q) && st_q == ST_SINGLE |->
    busAddr_q == sPtr_q[act_q] && busWrite_q == singleDirWrite[act_q])
    else $error("single address wrong");
  done_clear_a: assert property (doneWrite[1] && !(act_q == 2'h1 && errNow) |=>
    !srcFault_q[1] && !dstFault_q[1] && !busy_q[1]) else $error("done write kept flags");
  irq_line_a: assert property (irqOnFinish[2] && done_q[2] ##1 irqOnFinish[2] |->
    irqLine_q[2]) else $error("interrupt missing");
endmodule : fdma_sequencer
`default_nettype wire

// [dv/fdma_bus_model.sv]
`timescale 1ns/1ns
`default_nettype none
// ----------------------------------
// Far side: arbiter and bus memory
// ----------------------------------
module fdma_bus_model (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [3:0] latency,
  input wire logic errEnable,
  input wire logic [31:0] errAddr,
  input wire logic busValid,
  input wire logic [31:0] busAddr,
  output logic busGrant,
  output logic [31:0] busRdata,
  output logic busAck,
  output logic busErr
);
  logic [3:0] waitCnt;
  logic [31:0] pattern;
  logic hitErr;
  // Read data is made from the address so every beat can be traced
  assign pattern = {busAddr[15:0], ~busAddr[15:0]};
  assign hitErr = errEnable && (busAddr == errAddr);
  // Answer after a set wait; between answers the data bus toggles,
  // so a late sample never finds the old data by luck
  always @(posedge clk) begin
    busAck <= 1'b0;
    busErr <= 1'b0;
    busRdata <= ~busRdata;
    busGrant <= rst_n;
    if (!rst_n) begin
      waitCnt <= 4'h0;
      busRdata <= 32'h0000_0000;
    end else if (busValid && !busAck && !busErr) begin
      if (waitCnt >= latency) begin
        waitCnt <= 4'h0;
        busErr <= hitErr;
        busAck <= !hitErr;
        busRdata <= pattern;
      end else begin
        waitCnt <= waitCnt + 4'h1;
      end
    end
  end
endmodule : fdma_bus_model
`default_nettype wire

// [dv/tb_top.sv]
`timescale 1ns/1ns
`default_nettype none
`include "fdma_map.svh"
module tb_top;
  import fdma_pkg::*;
  logic clk, rst_n, irqAck, busGrant, busAck, busErr, vecValid_q, busReq_q, busValid_q;
  logic busWrite_q, errEnable, reqPrev;
  logic [3:0] chStart, startBit_q, extReqEnable, extAskN, cycleSteal, singleAddr, singleDirWrite;
  logic [3:0] srcStep, dstStep, autoAlign, irqOnFinish, cfgLoad, doneWrite, done_q, busy_q;
  logic [3:0] pend_q, srcFault_q, dstFault_q, cfgFault_q, irqLine_q, latency;
  fdma_width_t [3:0] srcWidth, dstWidth;
  fdma_bw_t [3:0] bwChunk;
  fdma_width_t busSize_q;
  fdma_cnt_t cfgCount;
  logic [3:0][7:0] irqVector;
  logic [1:0] irqAckChan;
  logic [7:0] vecData_q;
  logic [31:0] cfgSrc, cfgDst, busAddr_q, busWdata_q, busRdata, errAddr;
  logic [31:0] logA[$], logD[$];
  logic logW[$];
  int n_errors = 0;
  int samples_checked = 0;
  int reqRises = 0;
  int r0, k;

  fdma_sequencer dut (.clk, .rst_n, .chStart, .startBit_q, .extReqEnable, .extAskN, .cycleSteal,
    .singleAddr, .singleDirWrite, .srcStep, .dstStep, .autoAlign, .irqOnFinish, .srcWidth,
    .dstWidth, .bwChunk, .cfgLoad, .cfgSrc, .cfgDst, .cfgCount, .doneWrite, .done_q, .busy_q,
    .pend_q, .srcFault_q, .dstFault_q, .cfgFault_q, .irqLine_q, .irqVector, .irqAck,
    .irqAckChan, .vecData_q, .vecValid_q, .busReq_q, .busGrant, .busValid_q, .busAddr_q,
    .busWrite_q, .busSize_q, .busWdata_q, .busRdata, .busAck, .busErr);
  fdma_bus_model mem (.clk, .rst_n, .latency, .errEnable, .errAddr, .busValid(busValid_q),
    .busAddr(busAddr_q), .busGrant, .busRdata, .busAck, .busErr);

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // Log each acknowledged bus cycle and each rise of the bus request
  always @(posedge clk) begin
    reqPrev <= busReq_q;
    if (busReq_q === 1'b1 && reqPrev === 1'b0) reqRises++;
    if (busValid_q === 1'b1 && busAck === 1'b1) begin
      logA.push_back(busAddr_q);
      logW.push_back(busWrite_q);
      logD.push_back(busWrite_q ? busWdata_q : busRdata);
    end
  end

  // ----------------------------------
  // Access tasks
  // ----------------------------------
  // Wide enough for a count packed with its status bits
  task automatic chk(input logic [63:0] got, input logic [63:0] exp, input string msg);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask : chk
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick
  task automatic load(input int ch, input logic [31:0] s, d, input fdma_cnt_t c);
    cfgLoad[ch] = 1'b1;
    cfgSrc = s;
    cfgDst = d;
    cfgCount = c;
    tick(1);
    cfgLoad = 4'h0;
    tick(1);
  endtask : load
  task automatic go(input logic [3:0] m);
    chStart = m;
    tick(1);
    chStart = 4'h0;
  endtask : go
  // Bounded wait for done, fault or a number of logged cycles
  task automatic waitEnd(input int ch, input int nLog);
    for (k = 0; k < 2000; k++) begin
      if (done_q[ch] === 1'b1 || cfgFault_q[ch] === 1'b1) break;
      if (nLog > 0 && logA.size() >= nLog) break;
      tick(1);
    end
    if (k == 2000) begin
      n_errors++;
      $display("[FAIL] %0t wait ran out", $time);
      summarize();
    end
    tick(3);
  endtask : waitEnd
  task automatic clr(input int ch);
    doneWrite[ch] = 1'b1;
    tick(1);
    doneWrite = 4'h0;
    tick(1);
    chk({done_q[ch], busy_q[ch], pend_q[ch], srcFault_q[ch], dstFault_q[ch], cfgFault_q[ch],
      irqLine_q[ch]}, 0, "flags after done write");
    logA.delete();
    logW.delete();
    logD.delete();
  endtask : clr
  task automatic expLog(input int i, input logic w, input logic [31:0] a);
    chk(logW[i], w, "direction");
    chk(logA[i], a, "address");
  endtask : expLog
  task automatic summarize;
    $display("errors %0d checks %0d", n_errors, samples_checked);
    if (n_errors == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : summarize

  // ----------------------------------
  // Scenarios
  // ----------------------------------
  initial begin
    {rst_n, chStart, extReqEnable, cycleSteal, singleAddr, singleDirWrite, dstStep} = '0;
    {autoAlign, cfgLoad, doneWrite, irqAck, irqAckChan, errEnable, errAddr} = '0;
    {srcWidth, dstWidth, bwChunk, cfgSrc, cfgDst, cfgCount, latency} = '0;
    extAskN = 4'hF;
    srcStep = 4'hF;
    irqOnFinish = 4'hF;
    irqVector = {8'h13, 8'h12, 8'h11, 8'h10};
    tick(10);
    rst_n = 1'b1;
    tick(1);
    chk({done_q, busy_q, busReq_q, busValid_q}, 0, "after reset");
    // Continuous long copy, fixed destination
    load(0, 32'h0000_0100, 32'h0000_0200, 24'h00_0008);
    go(4'h1);
    waitEnd(0, 0);
    chk(logA.size(), 4, "cycles");
    expLog(0, 0, 32'h0000_0100);
    expLog(1, 1, 32'h0000_0200);
    expLog(2, 0, 32'h0000_0104);
    expLog(3, 1, 32'h0000_0200);
    chk(logD[1], logD[0], "write data");
    chk({done_q[0], irqLine_q[0], startBit_q[0]}, 3'b110, "end state");
    clr(0);
    // Byte reads packed into one long write, slow memory
    latency = 4'h3;
    srcWidth[1] = `FDMA_W_BYTE;
    load(1, 32'h0000_0300, 32'h0000_0400, 24'h00_0004);
    go(4'h2);
    waitEnd(1, 0);
    chk(logA.size(), 5, "cycles");
    for (int i = 0; i < 4; i++) expLog(i, 0, 32'h0000_0300 + i);
    expLog(4, 1, 32'h0000_0400);
    chk(logD[4], {logD[3][7:0], logD[2][7:0], logD[1][7:0], logD[0][7:0]}, "packing");
    clr(1);
    srcWidth[1] = `FDMA_W_LONG;
    latency = 4'h0;
    // Cycle steal: one transfer per start
    cycleSteal[2] = 1'b1;
    load(2, 32'h0000_0900, 32'h0000_0A00, 24'h00_0008);
    go(4'h4);
    waitEnd(2, 2);
    tick(10);
    chk({logA.size(), done_q[2]}, {32'd2, 1'b0}, "one transfer");
    go(4'h4);
    waitEnd(2, 0);
    chk({logA.size(), done_q[2]}, {32'd4, 1'b1}, "second transfer");
    clr(2);
    cycleSteal[2] = 1'b0;
    // Read error on the second transfer halts the channel
    errEnable = 1'b1;
    errAddr = 32'h0000_0904;
    load(2, 32'h0000_0900, 32'h0000_0A00, 24'h00_0008);
    go(4'h4);
    waitEnd(2, 0);
    tick(10);
    chk({logA.size(), srcFault_q[2], done_q[2]}, {32'd2, 2'b11}, "bus error");
    clr(2);
    errEnable = 1'b0;
    // Misaligned source and zero count: no bus cycle
    for (int i = 0; i < 2; i++) begin
      load(3, i ? 32'h0000_0102 : 32'h0000_0100, 32'h0000_0200, i ? 24'h00_0008 : 24'h00_0000);
      go(4'h8);
      waitEnd(3, 0);
      chk({logA.size(), cfgFault_q[3], irqLine_q[3]}, {32'd0, 2'b11}, "config");
      clr(3);
    end
    // Single address, both directions, source pointer only
    singleAddr[1] = 1'b1;
    for (int d = 0; d < 2; d++) begin
      singleDirWrite[1] = d[0];
      load(1, 32'h0000_0500, 32'h0000_0600, 24'h00_0004);
      go(4'h2);
      waitEnd(1, 0);
      chk({logA.size(), done_q[1]}, {32'd1, 1'b1}, "single");
      expLog(0, d[0], 32'h0000_0500);
      clr(1);
    end
    singleAddr[1] = 1'b0;
    // Pin request: ignored while disabled, one edge enough when enabled
    for (int e = 0; e < 2; e++) begin
      extReqEnable[0] = e[0];
      load(0, 32'h0000_0100, 32'h0000_0200, 24'h00_0004);
      extAskN[0] = 1'b0;
      tick(1);
      extAskN[0] = 1'b1;
      tick(30);
      chk({done_q[0], logA.size()}, e ? {1'b1, 32'd2} : 33'd0, "pin request");
      clr(0);
    end
    // Priority: equal chunks ascending, chunk zero outranks the previous
    for (int p = 0; p < 2; p++) begin
      bwChunk[0] = 3'h1;
      bwChunk[1] = p ? 3'h0 : 3'h1;
      load(0, 32'h0000_0700, 32'h0000_0200, 24'h00_0004);
      load(1, 32'h0000_0800, 32'h0000_0200, 24'h00_0004);
      go(4'h3);
      waitEnd(0, 4);
      chk(logA[0], p ? 32'h0000_0800 : 32'h0000_0700, "winner");
      waitEnd(1, 0);
      clr(0);
      clr(1);
    end
    // Chunk boundary at 512 bytes: one extra request rise, none unlimited
    for (int c = 1; c >= 0; c--) begin
      bwChunk[0] = c[2:0];
      r0 = reqRises;
      load(0, 32'h0000_1000, 32'h0000_0200, 24'h00_0204);
      go(4'h1);
      waitEnd(0, 0);
      chk(reqRises - r0, c + 1, "request rises");
      chk(logA.size(), 258, "transfers");
      clr(0);
    end
    // Vector returned for the acknowledged channel
    irqAck = 1'b1;
    for (int ch = 0; ch < 4; ch++) begin
      irqAckChan = ch[1:0];
      tick(1);
      chk({vecValid_q, vecData_q}, {1'b1, irqVector[ch]}, "vector");
    end
    irqAck = 1'b0;
    // Four long reads buffered, then line written back in the same order
    dstWidth[2] = `FDMA_W_LINE;
    dstStep[2] = 1'b1;
    load(2, 32'h0000_0B00, 32'h0000_0C00, 24'h00_0010);
    go(4'h4);
    waitEnd(2, 0);
    chk({logA.size(), done_q[2], busSize_q}, {32'd8, 1'b1, `FDMA_W_LINE}, "line beats");
    for (k = 0; k < 4; k++) begin
      expLog(k + 4, 1, 32'h0000_0C00 + 4 * k);
      chk(logD[k + 4], logD[k], "fifo order");
    end
    summarize();
  end
endmodule : tb_top
`default_nettype wire
